// ==== hdl/srp_params.svh ====
// constants shared by both ends of the serial register port
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH
`define SRP_FRAME_BITS 24
`define SRP_HDR_BITS 16
`define SRP_ADDR_W 15
`define SRP_BYTE_W 8
`define SRP_HDR_LAST 4'hf
`define SRP_BIT_LAST 3'h7
`define SRP_OP_READ 1'b1
`define SRP_OP_WRITE 1'b0
`define SRP_SCLK_PERIOD_NS 200
`define SRP_SYS_PERIOD_NS 25
`define SRP_HALF_CYC ((`SRP_SCLK_PERIOD_NS / 2) / `SRP_SYS_PERIOD_NS)
`define SRP_MEM_AW 6
`define SRP_LEN_W 4
`define SRP_CNT_W 12
`endif

// ==== hdl/srp_pkg.sv ====
// types shared by both ends of the serial register port
`include "srp_params.svh"
package srp_pkg;
    typedef logic [`SRP_ADDR_W-1:0] srp_addr_t;
    typedef logic [`SRP_BYTE_W-1:0] srp_byte_t;
    // device frame phases, gray along idle -> header -> data -> hold
    typedef enum logic [1:0] {
        SRP_D_IDLE = 2'b00,
        SRP_D_HDR = 2'b01,
        SRP_D_DATA = 2'b11,
        SRP_D_HOLD = 2'b10
    } srp_dev_state_t;
    // host frame phases, gray along idle -> setup -> run -> end
    typedef enum logic [1:0] {
        SRP_H_IDLE = 2'b00,
        SRP_H_SETUP = 2'b01,
        SRP_H_RUN = 2'b11,
        SRP_H_END = 2'b10
    } srp_host_state_t;
endpackage

// ==== hdl/srp_if.sv ====
// four-wire serial link between host and device
`timescale 1ns/1ps
interface srp_if;
    logic sclk;        // serial clock, made by the host
    logic port_select_n; // frame select, active low
    logic port_serial_in; // host to device data
    logic sdo_out;     // device data out value
    logic sdo_oe;      // device drives serial out
    wire port_serial_out; // serial out line as the host sees it
    // a released line reads low; the host only samples it in data bits
    assign port_serial_out = sdo_oe & sdo_out;
    modport device (
        input sclk,
        input port_select_n,
        input port_serial_in,
        output sdo_out,
        output sdo_oe
    );
    modport host (
        output sclk,
        output port_select_n,
        output port_serial_in,
        input port_serial_out
    );
endinterface

// ==== hdl/srp_sync.sv ====
// two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module srp_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    input wire logic [W-1:0] async_in, // pins from outside the domain
    output logic [W-1:0] level, // synchronised level
    output logic [W-1:0] rise, // one-cycle pulse on rising edge
    output logic [W-1:0] fall // one-cycle pulse on falling edge
);
    logic [W-1:0] meta;
    logic [W-1:0] prev;
    // first flop feeds only the second; edges compare flop two and three
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= '0;
            level <= '0;
            prev <= '0;
        end else begin
            meta <= async_in;
            level <= meta;
            prev <= level;
        end
    end
    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule

// ==== hdl/srp_device.sv ====
// device end of the serial register port with its register store
`timescale 1ns/1ps
`include "srp_params.svh"
module srp_device #(
    parameter int MEM_AW = `SRP_MEM_AW
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    srp_if.device link, // serial link
    input wire logic address_step_up, // 1: stream ascends, 0: descends
    input wire logic address_hold, // 1: no streaming past first byte
    output srp_pkg::srp_byte_t wr_data, // byte just written
    output srp_pkg::srp_addr_t wr_addr, // address just written
    output logic wr_strobe, // one-cycle pulse per stored byte
    output logic frame_active // select seen low
);
    import srp_pkg::*;

    // ********************************
    // pin synchronisation
    // ********************************
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_n;
    logic sdi_bit;

    // clock is sampled, not used as a clock: any rate below sys/8 works
    srp_sync #(.W(3)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({link.sclk, ~link.port_select_n, link.port_serial_in}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );
    assign sclk_rise = pin_rise[2];
    assign sclk_fall = pin_fall[2];
    // select is synchronised active high so that the flops' reset value
    // reads as deselected; otherwise a false frame would follow reset
    assign sel_n = ~pin_level[1];
    assign sdi_bit = pin_level[0];

    // ********************************
    // frame sequencing
    // ********************************
    srp_dev_state_t state;
    logic [3:0] hdr_cnt;
    logic [14:0] hdr_sh;
    logic [2:0] bit_cnt;
    logic [6:0] data_sh;
    logic op_read;
    srp_addr_t addr;
    srp_byte_t out_byte;
    logic byte_done;
    srp_addr_t next_addr;
    srp_byte_t mem [2**MEM_AW];

    // a byte completes on the eighth sampled rise of the data phase
    assign byte_done = (state == SRP_D_DATA) && sclk_rise && (bit_cnt == `SRP_BIT_LAST);
    // streaming walks the address one byte at a time
    assign next_addr = address_step_up ? addr + 1'b1 : addr - 1'b1;

    // past idle, state only moves on sampled rises or on deselect, so a stopped clock holds it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= SRP_D_IDLE;
        end else if (sel_n) begin
            state <= SRP_D_IDLE;
        end else begin
            case (state)
                SRP_D_IDLE: begin
                    state <= SRP_D_HDR;
                end
                SRP_D_HDR: begin
                    if (sclk_rise && hdr_cnt == `SRP_HDR_LAST) begin
                        state <= SRP_D_DATA;
                    end
                end
                SRP_D_DATA: begin
                    if (byte_done && address_hold) begin
                        state <= SRP_D_HOLD;
                    end
                end
                SRP_D_HOLD: begin
                    state <= SRP_D_HOLD;
                end
                default: begin
                    state <= SRP_D_IDLE;
                end
            endcase
        end
    end

    // header shifter: flag then fifteen address bits, msb first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hdr_cnt <= '0;
            hdr_sh <= '0;
        end else if (state != SRP_D_HDR) begin
            hdr_cnt <= '0;
        end else if (sclk_rise) begin
            hdr_cnt <= hdr_cnt + 1'b1;
            hdr_sh <= {hdr_sh[13:0], sdi_bit};
        end
    end

    // data byte counter and address, reloaded at end of header
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_cnt <= '0;
            data_sh <= '0;
            op_read <= `SRP_OP_WRITE;
            addr <= '0;
        end else if (state == SRP_D_HDR && sclk_rise && hdr_cnt == `SRP_HDR_LAST) begin
            op_read <= hdr_sh[14];
            addr <= {hdr_sh[13:0], sdi_bit};
            bit_cnt <= '0;
        end else if (state == SRP_D_DATA && sclk_rise) begin
            bit_cnt <= bit_cnt + 1'b1;
            data_sh <= {data_sh[5:0], sdi_bit};
            if (byte_done) begin
                addr <= next_addr;
            end
        end
    end

    // register store; multi-byte values sit lsb first at rising addresses
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2**MEM_AW; i++) begin
                mem[i] <= '0;
            end
        end else if (byte_done && !op_read) begin
            mem[addr[MEM_AW-1:0]] <= {data_sh, sdi_bit};
        end
    end

    // read byte latched at header end and again at each stream step
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_byte <= '0;
        end else if (state == SRP_D_HDR && sclk_rise && hdr_cnt == `SRP_HDR_LAST) begin
            out_byte <= mem[{hdr_sh[MEM_AW-2:0], sdi_bit}];
        end else if (byte_done) begin
            out_byte <= mem[next_addr[MEM_AW-1:0]];
        end
    end

    // ********************************
    // serial output
    // ********************************
    // new bit after each falling edge gives the host a full half period
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.sdo_out <= 1'b0;
            link.sdo_oe <= 1'b0;
        end else if (sel_n || state != SRP_D_DATA || !op_read) begin
            link.sdo_out <= 1'b0;
            link.sdo_oe <= 1'b0;
        end else if (sclk_fall) begin
            link.sdo_out <= out_byte[~bit_cnt];
            link.sdo_oe <= 1'b1;
        end
    end

    // ********************************
    // user side
    // ********************************
    // strobe only on a completed byte, so a byte cut short by deselect stores nothing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_strobe <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            frame_active <= 1'b0;
        end else begin
            wr_strobe <= byte_done && !op_read;
            frame_active <= !sel_n;
            if (byte_done && !op_read) begin
                wr_addr <= addr;
                wr_data <= {data_sh, sdi_bit};
            end
        end
    end
endmodule

// ==== hdl/srp_host.sv ====
// host end of the serial register port: frames user requests onto the link
`timescale 1ns/1ps
`include "srp_params.svh"
module srp_host #(
    parameter int HALF_CYC = `SRP_HALF_CYC
) (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    srp_if.host link, // serial link
    input wire logic req_valid, // start a transfer
    input wire logic req_read, // 1 read, 0 write
    input wire srp_pkg::srp_addr_t req_addr, // first register address
    input wire logic [`SRP_LEN_W-1:0] req_len, // bytes minus one
    input wire srp_pkg::srp_byte_t wdata, // write byte, next one after take
    input wire logic cal_busy, // converter calibrating, hold off
    output logic req_ready, // idle and able to accept
    output logic wdata_take, // pulse: wdata consumed
    output srp_pkg::srp_byte_t rdata, // last byte read
    output logic rdata_valid, // pulse: rdata new
    output logic done // pulse: frame finished
);
    import srp_pkg::*;

    // ********************************
    // clock divider and line sampling
    // ********************************
    localparam int CW = $clog2(HALF_CYC + 1);
    logic [CW-1:0] div_cnt;
    logic tick;
    logic so_level;
    srp_host_state_t state;
    logic [`SRP_CNT_W-1:0] bit_cnt;
    logic [`SRP_CNT_W-1:0] bit_total;
    logic [`SRP_CNT_W-1:0] next_cnt;
    logic [`SRP_FRAME_BITS-1:0] tx;
    logic rd_op;
    srp_byte_t rsh;

    assign tick = (div_cnt == CW'(HALF_CYC - 1));
    assign next_cnt = bit_cnt + 1'b1;

    // half-period enable, held clear in idle; sclk toggles only inside frames
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_cnt <= '0;
        end else if (tick || state == SRP_H_IDLE) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // serial out comes from another domain
    srp_sync #(.W(1)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(link.port_serial_out),
        .level(so_level),
        .rise(),
        .fall()
    );

    // ********************************
    // frame sequencing
    // ********************************
    // no new frame while calibration runs, it would spoil the result
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= SRP_H_IDLE;
            req_ready <= 1'b0;
            link.port_select_n <= 1'b1;
            link.sclk <= 1'b0;
            tx <= '0;
            bit_cnt <= '0;
            bit_total <= '0;
            rd_op <= 1'b0;
            done <= 1'b0;
            wdata_take <= 1'b0;
        end else begin
            done <= 1'b0;
            wdata_take <= 1'b0;
            case (state)
                SRP_H_IDLE: begin
                    req_ready <= !cal_busy;
                    if (req_valid && req_ready && !cal_busy) begin
                        state <= SRP_H_SETUP;
                        req_ready <= 1'b0;
                        link.port_select_n <= 1'b0;
                        tx <= {req_read, req_addr, req_read ? 8'h00 : wdata};
                        wdata_take <= !req_read;
                        rd_op <= req_read;
                        bit_cnt <= '0;
                        bit_total <= `SRP_CNT_W'(`SRP_HDR_BITS)
                            + {req_len, 3'h0} + `SRP_CNT_W'(`SRP_BYTE_W);
                    end
                end
                SRP_H_SETUP: begin
                    if (tick) begin
                        state <= SRP_H_RUN;
                        link.sclk <= 1'b1;
                    end
                end
                SRP_H_RUN: begin
                    if (tick && link.sclk) begin
                        link.sclk <= 1'b0;
                        bit_cnt <= next_cnt;
                        if (next_cnt == bit_total) begin
                            state <= SRP_H_END;
                        end else if (next_cnt[2:0] == 3'h0
                                && next_cnt > `SRP_CNT_W'(`SRP_HDR_BITS)) begin
                            tx <= {rd_op ? 8'h00 : wdata, 16'h0000};
                            wdata_take <= !rd_op;
                        end else begin
                            tx <= {tx[`SRP_FRAME_BITS-2:0], 1'b0};
                        end
                    end else if (tick) begin
                        link.sclk <= 1'b1;
                    end
                end
                SRP_H_END: begin
                    link.port_select_n <= 1'b1;
                    if (tick) begin
                        state <= SRP_H_IDLE;
                        done <= 1'b1;
                    end
                end
                default: begin
                    state <= SRP_H_IDLE;
                end
            endcase
        end
    end

    assign link.port_serial_in = tx[`SRP_FRAME_BITS-1];

    // read bits sampled at the end of each high phase, well after
    // the device changed them on the previous falling edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsh <= '0;
            rdata <= '0;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= 1'b0;
            if (state == SRP_H_RUN && tick && link.sclk && rd_op
                    && bit_cnt >= `SRP_CNT_W'(`SRP_HDR_BITS)) begin
                rsh <= {rsh[6:0], so_level};
                if (next_cnt[2:0] == 3'h0) begin
                    rdata <= {rsh[6:0], so_level};
                    rdata_valid <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== tb/srp_chk.sv ====
// concurrent checks on the link wires between host and device
`timescale 1ns/1ps
module srp_chk (
    input wire logic clk_sys, // system clock
    input wire logic rst, // async reset, active high
    input wire logic sclk, // serial clock
    input wire logic port_select_n, // frame select, active low
    input wire logic port_serial_in, // host to device data
    input wire logic sdo_out, // device data value
    input wire logic sdo_oe // device drive enable
);
    // ****************************************
    // frame bookkeeping
    // ****************************************
    logic sclk_q;
    logic [7:0] rises;
    logic rd_op;
    // delayed clock for rise detection
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end
    // rise count per frame, cleared while deselected
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rises <= 8'h00;
        end else if (port_select_n) begin
            rises <= 8'h00;
        end else if (sclk && !sclk_q) begin
            rises <= rises + 8'h01;
        end
    end
    // op flag is the first bit of the frame
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_op <= 1'b0;
        end else if (!port_select_n && sclk && !sclk_q && rises == 8'h00) begin
            rd_op <= port_serial_in;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_lead;
        !sclk [*3];
    endsequence
    sequence s_high_phase;
        sclk [*4] ##1 !sclk;
    endsequence
    a_sel_lead_low: assert property ($fell(port_select_n) |-> s_lead)
        else $error("clock rose too soon after select");
    a_idle_clk_low: assert property (port_select_n |-> !sclk)
        else $error("clock moved while deselected");
    a_frame_len_ok: assert property ($rose(port_select_n) |-> rises >= 8'd24 && rises[2:0] == 3'h0)
        else $error("frame not 24 plus whole bytes");
    a_clk_half_len: assert property ($rose(sclk) |-> s_high_phase)
        else $error("clock high phase wrong length");
    a_sdi_held_high: assert property (sclk && $past(sclk) |-> $stable(port_serial_in))
        else $error("serial in moved while clock high");
    a_oe_read_data: assert property (sdo_oe && !port_select_n |-> rd_op && rises >= 8'd16)
        else $error("output driven outside read data");
    a_oe_after_fall: assert property ($rose(sdo_oe) |-> !sclk)
        else $error("output enabled while clock high");
    a_sdo_moves_low: assert property (sdo_oe && $changed(sdo_out) |-> !sclk)
        else $error("read bit changed while clock high");
    a_oe_release: assert property ($rose(port_select_n) |-> ##[1:6] !sdo_oe)
        else $error("output still driven after deselect");
endmodule

// ==== tb/tb.sv ====
// bench for the serial register port: host and device joined back to back
`timescale 1ns/1ps
`include "srp_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    import srp_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam srp_byte_t SB [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic cal_busy = 1'b0;
    logic address_step_up = 1'b1;
    logic address_hold = 1'b0;
    srp_addr_t req_addr = '0;
    logic [`SRP_LEN_W-1:0] req_len = '0;
    srp_byte_t wdata = '0;
    logic req_ready, wdata_take, rdata_valid, done, wr_strobe, w2_strobe, w2_active;
    srp_byte_t rdata, wr_data, w2_data;
    srp_addr_t wr_addr, w2_addr;
    srp_addr_t got_a [8];
    srp_byte_t got_d [8];
    srp_byte_t rd_d [8];
    int nw, nr;
    int cyc = 0;
    int w2_cnt = 0;
    int fail_count = 0;
    int n_tests = 0;
    srp_if l1 ();
    srp_if l2 ();
    srp_host srp_host_i (.clk_sys(clk_sys), .rst(rst), .link(l1.host), .req_valid(req_valid),
        .req_read(req_read), .req_addr(req_addr), .req_len(req_len), .wdata(wdata),
        .cal_busy(cal_busy), .req_ready(req_ready), .wdata_take(wdata_take), .rdata(rdata),
        .rdata_valid(rdata_valid), .done(done));
    srp_device srp_device_i (.clk_sys(clk_sys), .rst(rst), .link(l1.device),
        .address_step_up(address_step_up), .address_hold(address_hold), .wr_data(wr_data),
        .wr_addr(wr_addr), .wr_strobe(wr_strobe), .frame_active());
    // second device faces the bench, which breaks framing on purpose
    srp_device srp_device_i2 (.clk_sys(clk_sys), .rst(rst), .link(l2.device),
        .address_step_up(1'b1), .address_hold(1'b0), .wr_data(w2_data),
        .wr_addr(w2_addr), .wr_strobe(w2_strobe), .frame_active(w2_active));
    srp_chk srp_chk_i (.clk_sys(clk_sys), .rst(rst), .sclk(l1.sclk),
        .port_select_n(l1.port_select_n), .port_serial_in(l1.port_serial_in),
        .sdo_out(l1.sdo_out), .sdo_oe(l1.sdo_oe));
    // clock, store counter on the second device, hang guard
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (w2_strobe === 1'b1) w2_cnt <= w2_cnt + 1;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // ****************************************
    // shared tasks
    // ****************************************
    // one host request; collects stores, read bytes and header bits off the wire
    task automatic xfer(input logic rd, input srp_addr_t a, input int n, input srp_byte_t b [4]);
        int k, idx, rises;
        logic ps, fin;
        logic [15:0] hdr;
        idx = 0; rises = 0; ps = 1'b0; fin = 1'b0; hdr = '0; nw = 0; nr = 0; k = 0;
        @(posedge clk_sys);
        while (req_ready !== 1'b1 && k < 200) begin @(posedge clk_sys); k++; end
        req_valid <= 1'b1; req_read <= rd; req_addr <= a;
        req_len <= `SRP_LEN_W'(n - 1); wdata <= b[0];
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (k = 0; k < 3000 && !fin; k++) begin
            @(posedge clk_sys);
            if (wdata_take === 1'b1) begin idx++; wdata <= b[idx % 4]; end
            if (rdata_valid === 1'b1 && nr < 8) begin rd_d[nr] = rdata; nr++; end
            if (wr_strobe === 1'b1 && nw < 8) begin
                got_a[nw] = wr_addr; got_d[nw] = wr_data; nw++;
            end
            if (l1.sclk === 1'b1 && ps === 1'b0) begin
                rises++;
                if (rises <= 16) hdr = {hdr[14:0], l1.port_serial_in};
            end
            ps = l1.sclk;
            fin = (done === 1'b1);
        end
        `CHK(fin, 1'b1)
        `CHK(hdr, {rd, a})
        `CHK(rises, 16 + 8 * n)
    endtask
    // bench-made frame on the second link; sel high drives select low to frame it, nb bits sent
    task automatic bb(input logic [23:0] v, input int nb, input logic sel);
        l2.port_select_n <= !sel;
        repeat (4) @(posedge clk_sys);
        `CHK(w2_active, sel)
        for (int i = 0; i < nb; i++) begin
            // clock parked low mid-frame; the device must keep its place
            if (i == 12) repeat (40) @(posedge clk_sys);
            l2.port_serial_in <= v[23-i];
            repeat (4) @(posedge clk_sys);
            l2.sclk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            l2.sclk <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        l2.port_select_n <= 1'b1;
        l2.port_serial_in <= !l2.port_serial_in;
        repeat (8) @(posedge clk_sys);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_single();
        xfer(1'b0, 15'h4005, 1, SB);
        `CHK(nw, 1)
        `CHK(got_a[0], 15'h4005)
        `CHK(got_d[0], 8'h11)
        xfer(1'b1, 15'h4005, 1, SB);
        `CHK(nw, 0)
        `CHK(rd_d[0], 8'h11)
        $display("test single done");
    endtask
    // three bytes written then read back, in either stepping direction
    task automatic t_stream(input logic up, input srp_addr_t a);
        int i;
        srp_addr_t e;
        address_step_up <= up;
        xfer(1'b0, a, 3, SB);
        `CHK(nw, 3)
        for (i = 0; i < 3; i++) begin
            e = up ? a + 15'(i) : a - 15'(i);
            `CHK(got_a[i], e)
            `CHK(got_d[i], SB[i])
        end
        xfer(1'b1, a, 3, SB);
        for (i = 0; i < 3; i++) `CHK(rd_d[i], SB[i])
        $display("test stream done");
    endtask
    task automatic t_hold();
        address_hold <= 1'b1;
        address_step_up <= 1'b1;
        xfer(1'b0, 15'h0030, 3, SB);
        `CHK(nw, 1)
        `CHK(got_a[0], 15'h0030)
        address_hold <= 1'b0;
        xfer(1'b1, 15'h0031, 1, SB);
        `CHK(rd_d[0], 8'h00)
        $display("test hold done");
    endtask
    // requests during calibration must never start a frame
    task automatic t_cal();
        logic low;
        low = 1'b0;
        cal_busy <= 1'b1;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        repeat (40) begin
            @(posedge clk_sys);
            if (l1.port_select_n !== 1'b1) low = 1'b1;
        end
        req_valid <= 1'b0;
        @(posedge clk_sys);
        cal_busy <= 1'b0;
        `CHK(low, 1'b0)
        $display("test cal done");
    endtask
    // unselected clocks, a cut-short frame, then a whole one
    task automatic t_abort();
        bb(24'h00075a, 24, 1'b0);
        `CHK(w2_cnt, 0)
        bb(24'h00075a, 20, 1'b1);
        `CHK(w2_cnt, 0)
        bb(24'h00075a, 24, 1'b1);
        `CHK(w2_cnt, 1)
        `CHK(w2_addr, 15'h0007)
        `CHK(w2_data, 8'h5a)
        $display("test abort done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        l2.sclk = 1'b0;
        l2.port_select_n = 1'b1;
        l2.port_serial_in = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_single();
        t_stream(1'b1, 15'h0010);
        t_stream(1'b0, 15'h0022);
        t_hold();
        t_cal();
        t_abort();
        tally_and_finish();
    end
endmodule
